// file: cufpc_consts.vh
`ifndef CUFPC_CONSTS_VH
`define CUFPC_CONSTS_VH

// Register byte offsets
`define CUFPC_ADDR_TX_HOLD 8'h00
`define CUFPC_ADDR_RX_HOLD 8'h04
`define CUFPC_ADDR_MIXED_STAT 8'h08
`define CUFPC_ADDR_FIFO_CTRL 8'h0C
`define CUFPC_ADDR_UART_STAT 8'h10
`define CUFPC_ADDR_UART_CFG2 8'h14
`define CUFPC_ADDR_CARD_SEL 8'h18
`define CUFPC_ADDR_IRQ_STAT 8'h1C
`define CUFPC_ADDR_IRQ_MASK 8'h20

// Fifo control fields
`define CUFPC_FCR_DEPTH_LSB 0
`define CUFPC_FCR_DEPTH_MSB 2
`define CUFPC_FCR_LIMIT_LSB 4
`define CUFPC_FCR_LIMIT_MSB 6
`define CUFPC_FCR_RESET 3'h0

// Card select fields
`define CUFPC_CSR_RUN 0
`define CUFPC_CSR_TX_MODE 1
`define CUFPC_CSR_LAST_CHAR 2
`define CUFPC_CSR_PROTO_T1 3

// Status fields
`define CUFPC_USR_FLAG 0
`define CUFPC_USR_PE 3
`define CUFPC_MSR_FLAG 0
`define CUFPC_MSR_EMPTY 6
`define CUFPC_CFG2_FLAG_MASK 0

// Interrupt event bits
`define CUFPC_EV_FLAG 0
`define CUFPC_EV_PE 1
`define CUFPC_EV_OVR 2
`define CUFPC_EV_W 3

// Character start times, tenths of an ETU, and in half-ETU ticks
`define CUFPC_RESEND_ETU_X10 150
`define CUFPC_MANUAL_ETU_X10 135
`define CUFPC_RESEND_HALF (`CUFPC_RESEND_ETU_X10 * 2 / 10)
`define CUFPC_MANUAL_HALF ((`CUFPC_MANUAL_ETU_X10 * 2 + 9) / 10)

`define CUFPC_FIFO_MAX 8

`endif

// file: cufpc_err_cnt.v
`timescale 1ns/1ps
`default_nettype none
module cufpc_err_cnt (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Control
   input wire clr_i,
   input wire inc_i,
   input wire [2:0] limit_i,
   // Result
   output wire hit_o,
   output reg done_o
);
   reg [2:0] cnt;

   // Count limit_i+1 errors; code 0 hits on the first
   assign hit_o = inc_i & ~done_o & (cnt == limit_i);

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 3'h0;
         done_o <= 1'b0;
      end else if (clr_i) begin
         cnt <= 3'h0;
         done_o <= 1'b0;
      end else if (hit_o) begin
         // Stays stopped until clr_i or reset clears it
         done_o <= 1'b1;
      end else if (inc_i & ~done_o) begin
         cnt <= cnt + 3'h1;
      end
   end
endmodule
`default_nettype wire

// file: cufpc_rx_fifo.v
`timescale 1ns/1ps
`default_nettype none
`include "cufpc_consts.vh"
module cufpc_rx_fifo (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Fill side
   input wire push_i,
   input wire [7:0] data_i,
   input wire [2:0] depth_sel_i,
   // Drain side
   input wire pop_i,
   output wire [7:0] head_o,
   // State
   output wire full_o,
   output wire empty_o,
   output wire ovr_o
);
   reg [7:0] mem [0:`CUFPC_FIFO_MAX-1];
   reg [2:0] wp;
   reg [2:0] rp;
   reg [3:0] cnt;
   wire [3:0] depth;
   wire do_push;
   wire do_pop;

   assign depth = {1'b0, depth_sel_i} + 4'h1;
   // Shrinking the depth below the fill level just blocks further pushes
   assign full_o = (cnt >= depth);
   assign empty_o = (cnt == 4'h0);
   assign do_pop = pop_i & ~empty_o;
   assign do_push = push_i & (~full_o | do_pop);
   assign ovr_o = push_i & ~do_push;
   assign head_o = mem[rp];

   always @(posedge clk_i) begin
      if (do_push) begin
         mem[wp] <= data_i;
      end
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp <= 3'h0;
         rp <= 3'h0;
         cnt <= 4'h0;
      end else begin
         if (do_push) begin
            wp <= wp + 3'h1;
         end
         if (do_pop) begin
            rp <= rp + 3'h1;
         end
         if (do_push & ~do_pop) begin
            cnt <= cnt + 4'h1;
         end else if (do_pop & ~do_push) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: cufpc_top.v
// How it works
// - Switching the interface from reception to transmission sets the empty/full flag.
// - Each transmitted character sets the flag, except a clean character sent in last-character mode.
// - The flag sets when the reception fifo reaches its selected depth.
// - Reset, run bit low, a transmit write, a receive read or a switch to reception clear the flag.
// - The parity error limit code 0..7 means 1..8 errors before the parity error flag and interrupt.
// - In T=0 a correct character before the limit clears the parity error count.
// - In T=0 the parity error flag holds until software reads the status register.
// - In T=0 a NAKed character is resent automatically up to the limit count, starting at 15 ETU.
// - With limit code 0 there is no resend, and a rewritten character starts at 13.5 ETU.
// - In T=1 the count is ignored and the first wrong parity character sets the parity error flag.
// - The depth code 0..7 selects a reception fifo depth of 1..8.
// - The interrupt pin falls while the empty/full flag is set and not masked.
// - In T=0 a character with bad parity is dropped and the error count advances.
`timescale 1ns/1ps
`default_nettype none
`include "cufpc_consts.vh"
module cufpc_top (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Register port
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // Character framer, receive
   input wire half_etu_tick_i,
   input wire rx_valid_i,
   input wire [7:0] rx_data_i,
   input wire rx_parity_err_i,
   // Character framer, transmit
   input wire tx_done_i,
   input wire tx_nak_i,
   output reg tx_start_o,
   output reg [7:0] tx_data_o,
   output reg tx_mode_o,
   // Interrupts
   output reg irq_out_n_o,
   output reg irq_o
);
   // Software registers
   reg [2:0] parity_error_limit;
   reg [2:0] fifo_depth_sel;
   reg interface_run_bit;
   reg last_char_tx_mode;
   reg proto_t1;
   reg flag_irq_mask;
   reg [`CUFPC_EV_W-1:0] irq_stat;
   reg [`CUFPC_EV_W-1:0] irq_mask;

   // Block state
   reg tx_empty_rx_full_flag;
   reg parity_error_flag;
   reg full_q;
   reg [4:0] half_cnt;
   reg manual_pend;
   reg resend_pend;

   // Next values
   reg next_flag;
   reg next_pe;
   reg [`CUFPC_EV_W-1:0] next_irq_stat;
   reg [7:0] next_rdata;

   // Decodes
   wire wr_tx_hold;
   wire wr_fcr;
   wire wr_csr;
   wire wr_cfg2;
   wire wr_istat;
   wire wr_imask;
   wire rd_rx_hold;
   wire rd_usr;
   wire mode_up;
   wire mode_down;

   // Receive path
   wire rx_store;
   wire rx_bad_t0;
   wire rx_good_t0;
   wire rx_hit;
   wire fifo_full;
   wire fifo_empty;
   wire fifo_ovr;
   wire [7:0] fifo_head;

   // Transmit path
   wire tx_naked;
   wire tx_hit;
   wire tx_done_cnt;
   wire tx_resend;
   wire tx_char_set;
   wire resend_go;
   wire manual_go;

   // Events
   wire flag_set;
   wire flag_clr;
   wire pe_set;
   wire [`CUFPC_EV_W-1:0] ev;

   assign wr_tx_hold = wr_i & (addr_i == `CUFPC_ADDR_TX_HOLD);
   assign wr_fcr = wr_i & (addr_i == `CUFPC_ADDR_FIFO_CTRL);
   assign wr_csr = wr_i & (addr_i == `CUFPC_ADDR_CARD_SEL);
   assign wr_cfg2 = wr_i & (addr_i == `CUFPC_ADDR_UART_CFG2);
   assign wr_istat = wr_i & (addr_i == `CUFPC_ADDR_IRQ_STAT);
   assign wr_imask = wr_i & (addr_i == `CUFPC_ADDR_IRQ_MASK);
   assign rd_rx_hold = rd_i & (addr_i == `CUFPC_ADDR_RX_HOLD);
   assign rd_usr = rd_i & (addr_i == `CUFPC_ADDR_UART_STAT);

   // Mode changes as written through the card select register
   assign mode_up = wr_csr & wdata_i[`CUFPC_CSR_TX_MODE] & ~tx_mode_o;
   assign mode_down = wr_csr & ~wdata_i[`CUFPC_CSR_TX_MODE] & tx_mode_o;

   // Receive: T=0 drops bad parity, T=1 keeps it
   assign rx_bad_t0 = rx_valid_i & rx_parity_err_i & ~proto_t1;
   assign rx_good_t0 = rx_valid_i & ~rx_parity_err_i & ~proto_t1;
   assign rx_store = interface_run_bit & rx_valid_i & (proto_t1 | ~rx_parity_err_i);

   cufpc_err_cnt u_rx_err (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i(rx_good_t0 | wr_fcr),
      .inc_i(rx_bad_t0),
      .limit_i(parity_error_limit),
      .hit_o(rx_hit),
      .done_o()
   );

   cufpc_rx_fifo u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(rx_store),
      .data_i(rx_data_i),
      .depth_sel_i(fifo_depth_sel),
      .pop_i(rd_rx_hold),
      .head_o(fifo_head),
      .full_o(fifo_full),
      .empty_o(fifo_empty),
      .ovr_o(fifo_ovr)
   );

   // Transmit: NAK counting shares the same limit field
   assign tx_naked = tx_done_i & tx_nak_i & ~proto_t1;

   cufpc_err_cnt u_tx_nak (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i((tx_done_i & ~tx_nak_i) | wr_fcr | wr_tx_hold),
      .inc_i(tx_naked),
      .limit_i(parity_error_limit),
      .hit_o(tx_hit),
      .done_o(tx_done_cnt)
   );

   // With limit 0 the first NAK hits, so no resend is queued
   assign tx_resend = tx_naked & ~tx_hit & ~tx_done_cnt;
   assign tx_char_set = tx_done_i & ~(last_char_tx_mode & ~tx_nak_i);
   assign resend_go = resend_pend & ~tx_start_o & (half_cnt >= `CUFPC_RESEND_HALF);
   assign manual_go = manual_pend & ~resend_pend & ~tx_start_o & (half_cnt >= `CUFPC_MANUAL_HALF);

   // PE: T=1 on first bad character, T=0 on the programmed count
   assign pe_set = (proto_t1 & rx_valid_i & rx_parity_err_i) | rx_hit | tx_hit;

   assign flag_set = mode_up | tx_char_set | (fifo_full & ~full_q);
   assign flag_clr = wr_tx_hold | rd_rx_hold | mode_down;
   assign ev = {fifo_ovr, pe_set, flag_set};

   always @* begin
      // Set wins over a same-cycle clear; only a stopped interface overrides
      if (~interface_run_bit) begin
         next_flag = 1'b0;
      end else if (flag_set) begin
         next_flag = 1'b1;
      end else if (flag_clr) begin
         next_flag = 1'b0;
      end else begin
         next_flag = tx_empty_rx_full_flag;
      end
      if (pe_set) begin
         next_pe = 1'b1;
      end else if (rd_usr) begin
         next_pe = 1'b0;
      end else begin
         next_pe = parity_error_flag;
      end
      next_irq_stat = irq_stat;
      if (wr_istat) begin
         next_irq_stat = irq_stat & ~wdata_i[`CUFPC_EV_W-1:0];
      end
      next_irq_stat = next_irq_stat | ev;
   end

   always @* begin
      next_rdata = 8'h00;
      case (addr_i)
         `CUFPC_ADDR_RX_HOLD: begin
            next_rdata = fifo_head;
         end
         `CUFPC_ADDR_MIXED_STAT: begin
            next_rdata[`CUFPC_MSR_EMPTY] = fifo_empty;
            next_rdata[`CUFPC_MSR_FLAG] = tx_empty_rx_full_flag;
         end
         `CUFPC_ADDR_UART_STAT: begin
            next_rdata[`CUFPC_USR_PE] = parity_error_flag;
            next_rdata[`CUFPC_USR_FLAG] = tx_empty_rx_full_flag;
         end
         `CUFPC_ADDR_UART_CFG2: begin
            next_rdata[`CUFPC_CFG2_FLAG_MASK] = flag_irq_mask;
         end
         `CUFPC_ADDR_CARD_SEL: begin
            next_rdata[`CUFPC_CSR_RUN] = interface_run_bit;
            next_rdata[`CUFPC_CSR_TX_MODE] = tx_mode_o;
            next_rdata[`CUFPC_CSR_LAST_CHAR] = last_char_tx_mode;
            next_rdata[`CUFPC_CSR_PROTO_T1] = proto_t1;
         end
         `CUFPC_ADDR_IRQ_STAT: begin
            next_rdata[`CUFPC_EV_W-1:0] = irq_stat;
         end
         `CUFPC_ADDR_IRQ_MASK: begin
            next_rdata[`CUFPC_EV_W-1:0] = irq_mask;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // Register file
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         parity_error_limit <= `CUFPC_FCR_RESET;
         fifo_depth_sel <= `CUFPC_FCR_RESET;
         interface_run_bit <= 1'b0;
         tx_mode_o <= 1'b0;
         last_char_tx_mode <= 1'b0;
         proto_t1 <= 1'b0;
         flag_irq_mask <= 1'b0;
         irq_mask <= {`CUFPC_EV_W{1'b0}};
         rdata_o <= 8'h00;
      end else begin
         if (wr_fcr) begin
            parity_error_limit <= wdata_i[`CUFPC_FCR_LIMIT_MSB:`CUFPC_FCR_LIMIT_LSB];
            fifo_depth_sel <= wdata_i[`CUFPC_FCR_DEPTH_MSB:`CUFPC_FCR_DEPTH_LSB];
         end
         if (wr_csr) begin
            interface_run_bit <= wdata_i[`CUFPC_CSR_RUN];
            tx_mode_o <= wdata_i[`CUFPC_CSR_TX_MODE];
            last_char_tx_mode <= wdata_i[`CUFPC_CSR_LAST_CHAR];
            proto_t1 <= wdata_i[`CUFPC_CSR_PROTO_T1];
         end
         if (wr_cfg2) begin
            flag_irq_mask <= wdata_i[`CUFPC_CFG2_FLAG_MASK];
         end
         if (wr_imask) begin
            irq_mask <= wdata_i[`CUFPC_EV_W-1:0];
         end
         rdata_o <= rd_i ? next_rdata : 8'h00;
      end
   end

   // Flags and interrupt pins
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_empty_rx_full_flag <= 1'b0;
         parity_error_flag <= 1'b0;
         full_q <= 1'b0;
         irq_stat <= {`CUFPC_EV_W{1'b0}};
         irq_out_n_o <= 1'b1;
         irq_o <= 1'b0;
      end else begin
         tx_empty_rx_full_flag <= next_flag;
         parity_error_flag <= next_pe;
         full_q <= fifo_full;
         irq_stat <= next_irq_stat;
         irq_out_n_o <= ~((next_flag & ~flag_irq_mask) | next_pe);
         irq_o <= |(next_irq_stat & irq_mask);
      end
   end

   // Character start timing in half ETUs since the last start
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         half_cnt <= 5'h1F;
         manual_pend <= 1'b0;
         resend_pend <= 1'b0;
         tx_start_o <= 1'b0;
         tx_data_o <= 8'h00;
      end else begin
         tx_start_o <= 1'b0;
         if (tx_start_o) begin
            half_cnt <= 5'h00;
         end else if (half_etu_tick_i & (half_cnt != 5'h1F)) begin
            half_cnt <= half_cnt + 5'h01;
         end
         if (wr_tx_hold) begin
            tx_data_o <= wdata_i;
            manual_pend <= 1'b1;
         end else if (manual_go & tx_mode_o & interface_run_bit) begin
            manual_pend <= 1'b0;
            tx_start_o <= 1'b1;
         end
         // A resend reuses the held character; stopping or leaving tx mode drops it
         if (~interface_run_bit | ~tx_mode_o) begin
            resend_pend <= 1'b0;
         end else if (tx_resend) begin
            resend_pend <= 1'b1;
         end else if (resend_go) begin
            resend_pend <= 1'b0;
            tx_start_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: cufpc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cufpc_asserts (
   // Watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic half_etu_tick_i,
   input wire logic rx_valid_i,
   input wire logic rx_parity_err_i,
   input wire logic tx_done_i,
   input wire logic tx_nak_i,
   input wire logic tx_start_o,
   input wire logic tx_mode_o,
   input wire logic irq_out_n_o
);
   // Shadows of software writes; nak count restarts like the design's, per character
   logic [3:0] card_select_reg;
   logic msk;
   logic [2:0] lim;
   logic [3:0] nakc;
   logic [4:0] tcnt;
   wire nak = tx_done_i && tx_nak_i && !card_select_reg[3];
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         card_select_reg <= 4'h0;
         msk <= 1'b0;
         lim <= 3'h0;
         nakc <= 4'h0;
         tcnt <= 5'h1F;
      end else begin
         if (wr_i && addr_i == 8'h18)
            card_select_reg <= wdata_i[3:0];
         if (wr_i && addr_i == 8'h14)
            msk <= wdata_i[0];
         if (wr_i && addr_i == 8'h0C)
            lim <= wdata_i[6:4];
         if ((wr_i && (addr_i == 8'h0C || addr_i == 8'h00)) || (tx_done_i && !tx_nak_i))
            nakc <= 4'h0;
         else if (nak)
            nakc <= nakc + 4'h1;
         if (tx_start_o)
            tcnt <= 5'h00;
         else if (half_etu_tick_i && tcnt != 5'h1F)
            tcnt <= tcnt + 5'h01;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside read slot");
   start_pulse_a: assert property (tx_start_o |=> !tx_start_o) else $error("start longer than one cycle");
   start_space_a: assert property (tx_start_o |-> tcnt >= 5'h1B) else $error("start before 13.5 ETU");
   start_mode_a: assert property (tx_start_o |-> tx_mode_o && card_select_reg[0]) else $error("start outside tx mode");
   mode_follow_a: assert property (wr_i && addr_i == 8'h18 |-> ##2 tx_mode_o == $past(wdata_i[1], 2))
      else $error("tx mode not following write");
   flag_tx_a: assert property (tx_done_i && !tx_nak_i && card_select_reg == 4'h3 && !msk |-> ##[1:2] !irq_out_n_o)
      else $error("flag irq missing after char");
   pe_t1_a: assert property (rx_valid_i && rx_parity_err_i && card_select_reg[3] && card_select_reg[0] |-> ##[1:2] !irq_out_n_o)
      else $error("first T1 parity error not flagged");
   nak_stop_a: assert property (nak && nakc >= lim |-> ##[1:2] !irq_out_n_o)
      else $error("nak limit not flagged");
   nak_pe_a: assert property (nak && nakc >= lim && msk |-> ##[1:2] !irq_out_n_o)
      else $error("nak limit not flagged with flag masked");
   resend_a: assert property (nak && card_select_reg[1:0] == 2'b11 && nakc < lim |-> ##[1:100] tx_start_o && tcnt >= 5'h1E)
      else $error("resend missing or early");
   cover property (nak);
   cover property (rx_valid_i && rx_parity_err_i);
   cover property (rd_i && addr_i == 8'h10);
endmodule
bind cufpc_top cufpc_asserts u_chk (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .half_etu_tick_i, .rx_valid_i, .rx_parity_err_i, .tx_done_i, .tx_nak_i, .tx_start_o, .tx_mode_o,
   .irq_out_n_o);
`default_nettype wire

// file: cufpc_card.sv
`timescale 1ns/1ps
`default_nettype none
module cufpc_card (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Framer side
   input wire logic tx_start_i,
   output logic half_etu_tick_o,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic rx_parity_err_o,
   output logic tx_done_o,
   output logic tx_nak_o
);
   int naks = 0;
   int starts = 0;
   int left = 0;
   initial begin
      half_etu_tick_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      rx_parity_err_o = 1'b0;
      tx_done_o = 1'b0;
      tx_nak_o = 1'b0;
   end
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         half_etu_tick_o <= 1'b0;
      else
         half_etu_tick_o <= ~half_etu_tick_o;
   end
   // Nak line toggles outside done so a stale level is never trusted
   always @(posedge clk_i) begin
      tx_done_o <= left == 1;
      tx_nak_o <= (left == 1) ? (naks > 0) : ~tx_nak_o;
      if (left == 1 && naks > 0)
         naks <= naks - 1;
      if (tx_start_i) begin
         starts <= starts + 1;
         left <= 8;
      end else if (left > 0)
         left <= left - 1;
   end
   task automatic send(input logic [7:0] d, input logic p);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= d;
      rx_parity_err_o <= p;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~d;
      rx_parity_err_o <= ~p;
   endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   wire [7:0] rdata_o;
   wire [7:0] rx_data_i;
   wire [7:0] tx_data_o;
   wire half_etu_tick_i, rx_valid_i, rx_parity_err_i, tx_done_i, tx_nak_i;
   wire tx_start_o, tx_mode_o, irq_out_n_o, irq_o;
   int failures = 0;
   int comparisons = 0;
   always #4 clk_i = ~clk_i;
   cufpc_top dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .half_etu_tick_i, .rx_valid_i,
      .rx_data_i, .rx_parity_err_i, .tx_done_i, .tx_nak_i, .tx_start_o, .tx_data_o, .tx_mode_o,
      .irq_out_n_o, .irq_o);
   cufpc_card card (.clk_i, .rst_i, .tx_start_i(tx_start_o), .half_etu_tick_o(half_etu_tick_i),
      .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_parity_err_o(rx_parity_err_i),
      .tx_done_o(tx_done_i), .tx_nak_o(tx_nak_i));
   task automatic final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk("rdata", rdata_o, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wtx;
      int i;
      i = 0;
      while (tx_done_i !== 1'b1 && i < 400) begin
         @(posedge clk_i) #1;
         i++;
      end
      chk("tx_done", tx_done_i, 1'b1);
      idle(3);
   endtask
   // Hang guard, far beyond the roughly 1100 cycles of the sequence
   initial begin
      #200000;
      failures++;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h08, 8'h40);
      rd(8'h10, 8'h00);
      rd(8'h0C, 8'h00);
      rd(8'h3C, 8'h00);
      chk("irq_n", irq_out_n_o, 1'b1);
      wr(8'h20, 8'h01);
      rd(8'h20, 8'h01);
      wr(8'h18, 8'h01);
      wr(8'h18, 8'h03);
      rd(8'h10, 8'h01);
      chk("irq_n", irq_out_n_o, 1'b0);
      chk("irq", irq_o, 1'b1);
      wr(8'h14, 8'h01);
      idle(2);
      chk("irq_n", irq_out_n_o, 1'b1);
      wr(8'h14, 8'h00);
      rd(8'h1C, 8'h01);
      wr(8'h1C, 8'h01);
      idle(2);
      chk("irq", irq_o, 1'b0);
      wr(8'h00, 8'hA5);
      rd(8'h10, 8'h00);
      wtx;
      chk("tx_data", tx_data_o, 8'hA5);
      rd(8'h10, 8'h01);
      wr(8'h18, 8'h07);
      wr(8'h00, 8'h5A);
      wtx;
      rd(8'h10, 8'h00);
      wr(8'h18, 8'h03);
      wr(8'h0C, 8'h27);
      card.naks = 2;
      card.starts = 0;
      wr(8'h00, 8'h3C);
      idle(300);
      chk("starts", card.starts[7:0], 8'h03);
      rd(8'h10, 8'h01);
      wr(8'h0C, 8'h07);
      wr(8'h14, 8'h01);
      card.naks = 1;
      card.starts = 0;
      wr(8'h00, 8'h77);
      idle(300);
      chk("starts", card.starts[7:0], 8'h01);
      chk("irq_n", irq_out_n_o, 1'b0);
      rd(8'h10, 8'h09);
      rd(8'h10, 8'h01);
      chk("irq_n", irq_out_n_o, 1'b1);
      wr(8'h14, 8'h00);
      wr(8'h00, 8'h77);
      wtx;
      chk("starts", card.starts[7:0], 8'h02);
      wr(8'h18, 8'h01);
      rd(8'h10, 8'h00);
      for (int d = 0; d < 8; d++) begin
         wr(8'h0C, d[7:0]);
         for (int i = 0; i <= d; i++) begin
            rd(8'h10, 8'h00);
            card.send(8'h10 + i[7:0], 1'b0);
         end
         rd(8'h10, 8'h01);
         for (int i = 0; i <= d; i++)
            rd(8'h04, 8'h10 + i[7:0]);
         rd(8'h08, 8'h40);
      end
      wr(8'h0C, 8'h00);
      card.send(8'hA1, 1'b0);
      card.send(8'hA2, 1'b0);
      rd(8'h1C, 8'h07);
      wr(8'h1C, 8'hFF);
      rd(8'h1C, 8'h00);
      rd(8'h04, 8'hA1);
      wr(8'h0C, 8'h27);
      card.send(8'hEE, 1'b1);
      card.send(8'hEE, 1'b1);
      card.send(8'h61, 1'b0);
      card.send(8'hEE, 1'b1);
      card.send(8'hEE, 1'b1);
      rd(8'h10, 8'h00);
      card.send(8'hEE, 1'b1);
      idle(3);
      chk("irq_n", irq_out_n_o, 1'b0);
      rd(8'h10, 8'h08);
      rd(8'h10, 8'h00);
      rd(8'h04, 8'h61);
      rd(8'h08, 8'h40);
      wr(8'h0C, 8'h77);
      wr(8'h18, 8'h09);
      card.send(8'h99, 1'b1);
      idle(3);
      chk("irq_n", irq_out_n_o, 1'b0);
      rd(8'h10, 8'h08);
      rd(8'h04, 8'h99);
      wr(8'h18, 8'h03);
      rd(8'h10, 8'h01);
      wr(8'h18, 8'h02);
      idle(1);
      rd(8'h10, 8'h00);
      final_report;
   end
endmodule
`default_nettype wire
